// ===== hbf_fault_manager.sv
// fault latching, output lockout and status word generation for ten half-bridges
//
// What this block does
// - previous command with bank bit 14 clear selects status frame for bridges 6..1.
// - previous command with bank bit 14 set addresses and reports bridges 10..7.
// - status bit 0 carries the thermal warning flag, one on fault.
// - prefix bit is thermal shutdown, bit 15 overcurrent, 14 supply, 13 underload.
// - bridge state field: 00 disabled, 01 overcurrent, 10 underload, 11 enabled.
// - low frame puts bridge 6 at bits 12:11 and bridge 5 at 10:9.
// - power-on reset loads command and status words with zero.
// - shutdown, overcurrent, supply, underload act on outputs; warning and states only report.
// - thermal shutdown latches outputs off until any clear; overcurrent until a clear for its bank.
// - supply over- and undervoltage lockouts recover by themselves, no latch.
// - configurations written during thermal or output supply lockout are taken when the lockout ends.
// - overvoltage locks all outputs only while the overvoltage lockout enable is one.
// - undervoltage on an output supply turns all outputs off and flags supply fault.
// - supply recovery restores programmed outputs and clears the supply fault flag.
// - during output supply undervoltage commands are still accepted and stored.
// - logic supply undervoltage turns outputs off and clears command and status.
// - first underload on any bridge starts one shared underload delay timer.
// - later underloads do not restart the running timer; they wait its remainder.
// - underload at expiry with shutdown enabled latches bridge off, flags, state 10.
// - with underload shutdown enable zero the drivers stay on.
// - a clear request clears underload flag and states for every bank.
`timescale 1ns/100ps
module hbf_fault_manager
  import hbf_pkg::*;
#(
  parameter int UL_DELAY = UL_DELAY_CYC
) (
  // system clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  input  wire logic                   ce_in,
  // link side, on the serial clock
  input  wire logic                   link_clk_in,
  input  wire logic [15:0]            cmd_word_in,
  input  wire logic                   cmd_strobe_in,
  output logic      [15:0]            status_word_out,
  output logic                        status_prefix_out,
  // analog fault comparators
  input  wire logic                   thermal_warning_in,
  input  wire logic                   thermal_shutdown_in,
  input  wire logic                   supply_undervoltage_in,
  input  wire logic                   supply_overvoltage_in,
  input  wire logic                   logic_undervoltage_in,
  input  wire logic [NUM_BRIDGES-1:0] overcurrent_in,
  input  wire logic [NUM_BRIDGES-1:0] underload_in,
  // bridge drivers
  output logic      [NUM_BRIDGES-1:0] bridge_drive_out,
  output logic      [NUM_BRIDGES-1:0] bridge_high_side_out
);

  localparam int CNT_W = $clog2(UL_DELAY + 1);

  typedef struct packed {
    logic [IN_W-1:0]        s1;
    logic [IN_W-1:0]        s2;
    logic [IN_W-1:0]        s3;
    logic [IN_W-1:0]        filt;
    logic                   ct1;
    logic                   ct2;
    logic                   ct3;
    logic                   ct_seen;
    logic                   ak1;
    logic                   ak2;
    logic                   ak3;
    logic [NUM_BRIDGES-1:0] en;
    logic [NUM_BRIDGES-1:0] cnf;
    logic                   ul_shdn_en;
    logic                   ov_lock_en;
    logic                   bank;
    logic [NUM_BRIDGES-1:0] oc_lat;
    logic [NUM_BRIDGES-1:0] ul_lat;
    logic                   tsd_lat;
    logic                   ul_flag;
    hbf_ul_t                ul_state;
    logic [CNT_W-1:0]       ul_cnt;
    logic [15:0]            status;
    logic                   prefix;
    logic [16:0]            snap;
    logic                   req;
    logic [NUM_BRIDGES-1:0] drive;
    logic [NUM_BRIDGES-1:0] hs;
  } hbf_main_t;

  typedef struct packed {
    logic [15:0] c_hold;
    logic        c_tog;
    logic        r1;
    logic        r2;
    logic        r3;
    logic        ack;
    logic [15:0] st;
    logic        pre;
  } hbf_link_t;

  hbf_main_t st;
  hbf_main_t next_st;
  hbf_link_t ls;
  hbf_link_t next_ls;

  logic [IN_W-1:0]        raw;
  logic                   cmd_new;
  logic                   clr_all;
  logic [NUM_BRIDGES-1:0] clr_oc;
  logic [NUM_BRIDGES-1:0] qual;
  logic                   lock;
  logic                   any_ul;
  logic                   vcc_low;

  assign raw = {underload_in, overcurrent_in, logic_undervoltage_in, supply_overvoltage_in,
                supply_undervoltage_in, thermal_shutdown_in, thermal_warning_in};

  // link domain: hold the last command word, hand status over by toggle handshake
  always_comb begin
    next_ls = ls;
    next_ls.r1 = st.req;
    next_ls.r2 = ls.r1;
    next_ls.r3 = ls.r2;
    if (cmd_strobe_in) begin
      next_ls.c_hold = cmd_word_in;
      next_ls.c_tog  = ~ls.c_tog;
    end
    // snapshot is held steady by the main side until the ack returns
    if ((ls.r2 == ls.r3) && (ls.r3 != ls.ack)) begin
      next_ls.st  = st.snap[15:0];
      next_ls.pre = st.snap[16];
      next_ls.ack = ls.r3;
    end
  end

  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ls        <= '0;
      ls.c_hold <= CMD_RESET;
      ls.st     <= STATUS_RESET;
    end else begin
      ls <= next_ls;
    end
  end

  assign status_word_out   = ls.st;
  assign status_prefix_out = ls.pre;

  // main domain
  always_comb begin
    next_st = st;
    cmd_new = 1'b0;
    clr_all = 1'b0;
    clr_oc  = '0;
    qual    = '0;

    // three-stage synchroniser, a change counts once stages two and three agree
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < IN_W; i++) begin
      next_st.filt[i] = (st.s2[i] & st.s3[i]) | (st.filt[i] & (st.s2[i] | st.s3[i]));
    end
    next_st.ct1 = ls.c_tog;
    next_st.ct2 = st.ct1;
    next_st.ct3 = st.ct2;
    next_st.ak1 = ls.ack;
    next_st.ak2 = st.ak1;
    next_st.ak3 = st.ak2;

    vcc_low = st.filt[IX_VCC];
    // only shutdown and supply faults feed the lockout; overvoltage gated by enable
    // supply terms are unlatched, lockout ends with the condition
    lock = st.tsd_lat | st.filt[IX_UV] | (st.filt[IX_OV] & st.ov_lock_en) | vcc_low;
    any_ul = |(st.filt[IX_UL +: NUM_BRIDGES] & st.drive);

    // commands are taken even while the output supply is low
    if ((st.ct2 == st.ct3) && (st.ct3 != st.ct_seen)) begin
      cmd_new = 1'b1;
      next_st.ct_seen = st.ct3;
      // bank bit steers which bridges this command and the next frame cover
      next_st.bank  = ls.c_hold[CB_BANK];
      next_st.ul_shdn_en = ls.c_hold[CB_UL_SHDN];
      next_st.ov_lock_en = ls.c_hold[CB_OV_LOCK];
      // clear request resets underload and thermal state whatever the bank
      clr_all = ls.c_hold[CB_CLEAR];
      for (int b = 0; b < NUM_BRIDGES; b++) begin
        // bridges 10..7 take the high bank, indexed from the bank base
        if ((b >= HIGH_BASE) == ls.c_hold[CB_BANK]) begin
          next_st.en[b]  = ls.c_hold[2 * (b - ((b >= HIGH_BASE) ? HIGH_BASE : 0)) + 2];
          next_st.cnf[b] = ls.c_hold[2 * (b - ((b >= HIGH_BASE) ? HIGH_BASE : 0)) + 1];
          // overcurrent release applies only to the selected bank
          clr_oc[b] = ls.c_hold[CB_CLEAR];
        end
      end
    end

    // one shared timer, started by the first underload on any bridge
    case (st.ul_state)
      UL_IDLE: begin
        if (any_ul) begin
          next_st.ul_state = UL_RUN;
          next_st.ul_cnt   = CNT_W'(UL_DELAY - 1);
        end
      end
      UL_RUN: begin
        // further underloads only see the time left on this count
        if (st.ul_cnt != '0) begin
          next_st.ul_cnt = st.ul_cnt - 1'b1;
        end else begin
          qual = st.filt[IX_UL +: NUM_BRIDGES] & st.drive;
          next_st.ul_state = UL_HOLD;
        end
      end
      UL_HOLD: begin
        // waiting for all underloads to clear stops an endless retrigger with shutdown off
        if (!any_ul) begin
          next_st.ul_state = UL_IDLE;
        end
      end
      default: begin
        next_st.ul_state = UL_IDLE;
      end
    endcase

    // a new fault wins over a clear in the same cycle
    for (int b = 0; b < NUM_BRIDGES; b++) begin
      next_st.oc_lat[b] = (st.filt[IX_OC + b] & st.drive[b]) | (st.oc_lat[b] & ~clr_oc[b]);
      // qualified underload latches the bridge off; not without the enable
      next_st.ul_lat[b] = (qual[b] & st.ul_shdn_en) | (st.ul_lat[b] & ~clr_all);
      // drivers follow the stored configuration once the lockout is gone
      next_st.drive[b] = st.en[b] & ~lock & ~st.oc_lat[b] & ~st.ul_lat[b];
      next_st.hs[b]    = st.en[b] & ~lock & ~st.oc_lat[b] & ~st.ul_lat[b] & st.cnf[b];
    end
    next_st.tsd_lat  = st.filt[IX_TSD] | (st.tsd_lat & ~clr_all);
    next_st.ul_flag  = (|qual) | (st.ul_flag & ~clr_all);

    // status frame for the bank of the previous command
    next_st.status = STATUS_RESET;
    for (int b = 0; b < NUM_BRIDGES; b++) begin
      if ((b >= HIGH_BASE) == st.bank) begin
        // field encoding, overcurrent ahead of underload
        // bridge n of a bank sits at bits 2n:2n-1
        if (st.oc_lat[b]) begin
          next_st.status[2 * (b - ((b >= HIGH_BASE) ? HIGH_BASE : 0)) + 1 +: 2] = ST_OVERCURRENT;
        end else if (st.ul_lat[b]) begin
          next_st.status[2 * (b - ((b >= HIGH_BASE) ? HIGH_BASE : 0)) + 1 +: 2] = ST_UNDERLOAD;
        end else if (st.drive[b]) begin
          next_st.status[2 * (b - ((b >= HIGH_BASE) ? HIGH_BASE : 0)) + 1 +: 2] = ST_ENABLED;
        end else begin
          next_st.status[2 * (b - ((b >= HIGH_BASE) ? HIGH_BASE : 0)) + 1 +: 2] = ST_DISABLED;
        end
        next_st.status[SB_OC] = next_st.status[SB_OC] | st.oc_lat[b];
      end
    end
    // flag positions; supply fault follows the synchronised supply state
    next_st.status[SB_SUPPLY] = st.filt[IX_UV] | st.filt[IX_OV];
    next_st.status[SB_UL]     = st.ul_flag;
    next_st.status[SB_WARN]   = st.filt[IX_WARN];
    next_st.prefix         = st.tsd_lat;

    // logic supply low wipes command and status state
    if (vcc_low) begin
      next_st.en       = '0;
      next_st.cnf      = '0;
      next_st.ul_shdn_en = 1'b0;
      next_st.ov_lock_en = 1'b0;
      next_st.bank       = 1'b0;
      next_st.oc_lat     = '0;
      next_st.ul_lat     = '0;
      next_st.tsd_lat    = 1'b0;
      next_st.ul_flag    = 1'b0;
      next_st.ul_state = UL_IDLE;
      next_st.ul_cnt   = '0;
      next_st.status   = STATUS_RESET;
      next_st.prefix   = 1'b0;
    end

    // publish a new snapshot only when the link side has taken the last one
    if ((st.ak2 == st.ak3) && (st.ak3 == st.req) && (st.snap != {st.prefix, st.status})) begin
      next_st.snap = {st.prefix, st.status};
      next_st.req  = ~st.req;
    end
  end

  // power-on reset clears command and status state
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st        <= '0;
      st.status <= STATUS_RESET;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign bridge_drive_out     = st.drive;
  assign bridge_high_side_out = st.hs;

  a_oc_forces_off: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && (st.oc_lat != '0) |=> (st.drive & $past(st.oc_lat)) == '0)
    else $error("bridge driven with overcurrent latched");

  a_oc_latch_holds: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && !vcc_low && ((st.oc_lat & ~clr_oc) != '0)
    |=> (st.oc_lat & $past(st.oc_lat & ~clr_oc)) == $past(st.oc_lat & ~clr_oc))
    else $error("overcurrent latch dropped without clear");

  a_uv_locks_all: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && st.filt[IX_UV] |=> (st.drive == '0) && ($past(vcc_low) || st.status[SB_SUPPLY]))
    else $error("undervoltage left outputs on or flag clear");

  a_ov_gated_lock: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && st.filt[IX_OV] && st.ov_lock_en |=> st.drive == '0)
    else $error("overvoltage with lockout enabled left outputs on");

  a_ul_timer_counts: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && !vcc_low && st.ul_state == UL_RUN && st.ul_cnt != '0
    |=> st.ul_state == UL_RUN && st.ul_cnt == CNT_W'($past(st.ul_cnt) - 1'b1))
    else $error("underload timer restarted or skipped");

  a_vcc_clears_words: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && vcc_low |=> st.en == '0 && st.status == STATUS_RESET && st.drive == '0)
    else $error("logic undervoltage did not clear state");

  a_field_bridge_six: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && !vcc_low && !st.bank && st.oc_lat[5]
    |=> st.status[12:11] == ST_OVERCURRENT && st.status[SB_OC])
    else $error("bridge six field wrong in low frame");

  a_no_ul_latch: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && !st.ul_shdn_en |=> (st.ul_lat & ~$past(st.ul_lat)) == '0)
    else $error("underload latched with shutdown disabled");

  a_ul_qualifies: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && !vcc_low && (qual != '0)
    |=> st.ul_flag ##1 (!$past(ce_in) || $past(vcc_low) || st.status[SB_UL]))
    else $error("qualified underload not flagged");

  a_cmd_bank_taken: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && cmd_new && !vcc_low |=> st.bank == $past(ls.c_hold[CB_BANK]))
    else $error("command word not stored");

endmodule

// ===== hbf_pkg.sv
// constants and types shared by the half-bridge fault and status manager
package hbf_pkg;

  // bridge layout
  localparam int NUM_BRIDGES = 10;
  localparam int HIGH_BASE   = 6;

  // command word bit positions
  localparam int CB_CLEAR   = 15;
  localparam int CB_BANK    = 14;
  localparam int CB_UL_SHDN = 13;
  localparam int CB_OV_LOCK = 0;

  // status word bit positions; the prefix bit is sent ahead of bit 15
  localparam int SB_OC     = 15;
  localparam int SB_SUPPLY = 14;
  localparam int SB_UL     = 13;
  localparam int SB_WARN   = 0;

  // values after reset
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // per-bridge output state field encodings
  localparam logic [1:0] ST_DISABLED    = 2'h0;
  localparam logic [1:0] ST_OVERCURRENT = 2'h1;
  localparam logic [1:0] ST_UNDERLOAD   = 2'h2;
  localparam logic [1:0] ST_ENABLED     = 2'h3;

  // positions of the fault inputs in the synchroniser vector
  localparam int IX_WARN = 0;
  localparam int IX_TSD = 1;
  localparam int IX_UV  = 2;
  localparam int IX_OV  = 3;
  localparam int IX_VCC = 4;
  localparam int IX_OC  = 5;
  localparam int IX_UL  = 15;
  localparam int IN_W   = 25;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int UL_DELAY_NS   = 200000;
  localparam int UL_DELAY_CYC  = (UL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // global underload timer states
  typedef enum logic [1:0] {UL_IDLE, UL_RUN, UL_HOLD} hbf_ul_t;

endpackage

// ===== hbf_host_model.sv
// host model: sends command frames on the link clock and samples the status frame
`timescale 1ns/100ps
module hbf_host_model (
  // link outputs
  output logic             link_clk_out,
  output logic      [15:0] cmd_word_out,
  output logic             cmd_strobe_out,
  // status inputs
  input  wire logic [15:0] status_word_in,
  input  wire logic        status_prefix_in
);
  initial begin
    link_clk_out   = 1'b0;
    cmd_word_out   = 16'h0000;
    cmd_strobe_out = 1'b0;
  end

  // clear request rides in word
  // clock runs only inside a frame; word is inverted once the strobe is gone
  task automatic xfer(input logic [15:0] w, input logic stb,
                      output logic [15:0] st, output logic pre);
    #7;
    for (int i = 0; i < 16; i++) begin
      #24 link_clk_out = 1'b1;
      if (i == 14) begin
        cmd_word_out   <= w;
        cmd_strobe_out <= stb;
      end
      if (i == 15) begin
        cmd_word_out   <= ~w;
        cmd_strobe_out <= 1'b0;
      end
      #24 link_clk_out = 1'b0;
    end
    st  = status_word_in;
    pre = status_prefix_in;
  endtask
endmodule

// ===== tb_top.sv
// self-checking bench for the half-bridge fault and status manager
`timescale 1ns/100ps
module tb_top;
  // short underload delay keeps the run brief
  localparam int UL_DLY = 20;
  typedef struct packed {
    logic [15:0] cmd;
    logic        warn;
    logic        ov;
    logic        uv;
    logic [9:0]  drv;
    logic [9:0]  hs;
    logic [15:0] st;
    logic [15:0] msk;
  } hbf_row_t;

  logic        clk_in;
  logic        nrst_in;
  logic        ce_in;
  logic        link_clk;
  logic        cmd_strobe;
  logic        prefix;
  logic        pre;
  logic        warn;
  logic        tsd;
  logic        suv;
  logic        sov;
  logic        luv;
  logic [15:0] cmd_word;
  logic [15:0] status_word;
  logic [15:0] st;
  logic [9:0]  oc;
  logic [9:0]  ul;
  logic [9:0]  drive;
  logic [9:0]  high_side;
  int          err_count;
  int          n_compared;

  // fields are masked where the lockout leaves them open
  hbf_row_t rows [9] = '{
    '{16'h1C00, 1'b0, 1'b0, 1'b0, 10'h030, 10'h020, 16'h1E00, 16'hFFFF},
    '{16'h1C00, 1'b1, 1'b0, 1'b0, 10'h030, 10'h020, 16'h1E01, 16'hFFFF},
    '{16'h4106, 1'b0, 1'b0, 1'b0, 10'h270, 10'h060, 16'h0186, 16'hFFFF},
    '{16'h1C00, 1'b0, 1'b1, 1'b0, 10'h270, 10'h060, 16'h5E00, 16'hFFFF},
    '{16'h1C01, 1'b0, 1'b1, 1'b0, 10'h000, 10'h000, 16'h4000, 16'hE001},
    '{16'h1C01, 1'b0, 1'b0, 1'b0, 10'h270, 10'h060, 16'h1E00, 16'hFFFF},
    '{16'h1C00, 1'b0, 1'b0, 1'b1, 10'h000, 10'h000, 16'h4000, 16'hE001},
    '{16'h0C00, 1'b0, 1'b0, 1'b1, 10'h000, 10'h000, 16'h4000, 16'hE001},
    '{16'h0C00, 1'b0, 1'b0, 1'b0, 10'h250, 10'h040, 16'h0600, 16'hFFFF}
  };

  hbf_fault_manager #(.UL_DELAY(UL_DLY)) dut (
    .clk_in                 (clk_in),
    .nrst_in                (nrst_in),
    .ce_in                  (ce_in),
    .link_clk_in            (link_clk),
    .cmd_word_in            (cmd_word),
    .cmd_strobe_in          (cmd_strobe),
    .status_word_out        (status_word),
    .status_prefix_out      (prefix),
    .thermal_warning_in     (warn),
    .thermal_shutdown_in    (tsd),
    .supply_undervoltage_in (suv),
    .supply_overvoltage_in  (sov),
    .logic_undervoltage_in  (luv),
    .overcurrent_in         (oc),
    .underload_in           (ul),
    .bridge_drive_out       (drive),
    .bridge_high_side_out   (high_side)
  );

  hbf_host_model host (
    .link_clk_out     (link_clk),
    .cmd_word_out     (cmd_word),
    .cmd_strobe_out   (cmd_strobe),
    .status_word_in   (status_word),
    .status_prefix_in (prefix)
  );

  always #12.5 clk_in = ~clk_in;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_drv(input logic [9:0] e);
    check("drive", {6'h00, drive}, {6'h00, e});
  endtask

  // status seen in a frame reflects the bank of the command before it
  task automatic frame(input logic [15:0] w);
    host.xfer(w, 1'b1, st, pre);
    repeat (20) @(posedge clk_in);
  endtask

  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk_in     = 1'b0;
    nrst_in    = 1'b0;
    ce_in      = 1'b1;
    {warn, tsd, suv, sov, luv} = 5'h00;
    oc         = 10'h000;
    ul         = 10'h000;
    err_count  = 0;
    n_compared = 0;
    // link edges while reset is low, no strobe
    fork
      host.xfer(16'h0000, 1'b0, st, pre);
    join_none
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk_drv(10'h000);
    check("status", status_word, 16'h0000);
    check("prefix", {15'h0000, prefix}, 16'h0000);
    repeat (24) @(posedge clk_in);
    foreach (rows[i]) begin
      {warn, sov, suv} <= {rows[i].warn, rows[i].ov, rows[i].uv};
      frame(rows[i].cmd);
      frame(rows[i].cmd);
      chk_drv(rows[i].drv);
      check("high_side", {6'h00, high_side}, {6'h00, rows[i].hs});
      check("status", st & rows[i].msk, rows[i].st);
    end
    // overcurrent pulse on bridge 6, then clears by bank
    frame(16'h1C00);
    oc <= 10'h020;
    repeat (6) @(posedge clk_in);
    oc <= 10'h000;
    repeat (10) @(posedge clk_in);
    chk_drv(10'h250);
    frame(16'h1C00);
    check("status", st, 16'h8E00);
    frame(16'hC106);
    chk_drv(10'h250);
    frame(16'h9C00);
    chk_drv(10'h270);
    // thermal shutdown pulse
    tsd <= 1'b1;
    repeat (6) @(posedge clk_in);
    tsd <= 1'b0;
    repeat (10) @(posedge clk_in);
    chk_drv(10'h000);
    frame(16'h1C00);
    check("prefix", {15'h0000, pre}, 16'h0001);
    frame(16'h9C00);
    chk_drv(10'h270);
    // second underload must not restart the shared timer
    frame(16'h3C00);
    ul <= 10'h010;
    repeat (UL_DLY / 2) @(posedge clk_in);
    ul <= 10'h030;
    repeat (4) @(posedge clk_in);
    chk_drv(10'h270);
    repeat (UL_DLY - 4) @(posedge clk_in);
    chk_drv(10'h240);
    ul <= 10'h000;
    frame(16'h3C00);
    check("status", st, 16'h3400);
    chk_drv(10'h240);
    frame(16'hE106);
    chk_drv(10'h270);
    // underload with shutdown disabled leaves drivers on
    frame(16'h1C00);
    ul <= 10'h010;
    repeat (2 * UL_DLY) @(posedge clk_in);
    chk_drv(10'h270);
    ul <= 10'h000;
    // clock enable low freezes the clk_in side, so a pulse meanwhile is never seen
    ce_in <= 1'b0;
    tsd   <= 1'b1;
    repeat (10) @(posedge clk_in);
    tsd   <= 1'b0;
    repeat (4) @(posedge clk_in);
    ce_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk_drv(10'h270);
    // logic supply undervoltage wipes configuration and status
    luv <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk_drv(10'h000);
    luv <= 1'b0;
    repeat (10) @(posedge clk_in);
    chk_drv(10'h000);
    frame(16'h0000);
    check("status", st, 16'h0000);
    // reset in mid-run with bridges on and a live status word
    frame(16'h1C00);
    frame(16'h1C00);
    chk_drv(10'h030);
    check("status", status_word, 16'h1E00);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk_drv(10'h000);
    check("status", status_word, 16'h0000);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk_drv(10'h000);
    check("prefix", {15'h0000, prefix}, 16'h0000);
    give_verdict;
  end
endmodule
